// ---- ivm_defs.svh ----
/*
  Constants of the interrupt vector map: source count, address width, slot indices, reset entry, boot start.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef IVM_DEFS_SVH
`define IVM_DEFS_SVH
`define IVM_NUM_SRC 26
`define IVM_ADDR_W 14
`define IVM_RESET_ADDR 14'h0000
`define IVM_SLOT_EXT0 5'h01
`define IVM_SLOT_PCG0 5'h03
`define IVM_SLOT_WDT 5'h06
`define IVM_SLOT_TB8A 5'h07
`define IVM_SLOT_TB8OVF 5'h09
`define IVM_SLOT_TW16CAP 5'h0A
`define IVM_SLOT_TW16OVF 5'h0D
`define IVM_SLOT_TA8A 5'h0E
`define IVM_SLOT_TA8OVF 5'h10
`define IVM_SLOT_SPI 5'h11
`define IVM_SLOT_SERRX 5'h12
`define IVM_SLOT_SERTX 5'h14
`define IVM_SLOT_ADC 5'h15
`define IVM_SLOT_NVRDY 5'h16
`define IVM_SLOT_ACMP 5'h17
`define IVM_SLOT_TWE 5'h18
`define IVM_SLOT_PSRDY 5'h19
`define IVM_SLOT_LAST 5'h1A
`define IVM_BOOT_START 14'h0F00
`endif

// ---- ivm_pkg.sv ----
/*
  Types of the interrupt vector map.
  Assumes ivm_defs.svh is on the include path.
*/
`include "ivm_defs.svh"
package ivm_pkg;
  // Family variant: smallest, middle, largest
  typedef enum logic [1:0] {
    IVM_VAR_SMALL = 2'h0,
    IVM_VAR_MID = 2'h1,
    IVM_VAR_LARGE = 2'h3
  } ivm_variant_e;
  typedef enum logic [1:0] {
    IVM_ST_IDLE = 2'h0,
    IVM_ST_VECT = 2'h1,
    IVM_ST_RESET = 2'h2
  } ivm_state_e;
  typedef logic [`IVM_ADDR_W-1:0] ivm_addr_t;
endpackage : ivm_pkg

// ---- ivm_vector_map.sv ----
/*
  Interrupt vector map: picks the winning pending request and hands the
  program counter its vector address; rst goes to the reset entry, a reset request to the fuse-selected target in the larger variants.
  Assumes requests and enables are synchronous to clk and the core raises
  vecAck for one cycle when it has taken the offered vector.
*/
// Operation
// - Slot 0 at 0x000 is the reset entry for rst and, fuse unprogrammed, for reset requests.
// - External request zero goes to 0x001, request one to 0x002.
// - Pin-change groups zero to two go to 0x003, 0x004, 0x005.
// - Watchdog 0x006; second 8-bit timer match A, B, overflow 0x007-0x009.
// - 16-bit timer capture 0x00A, match A/B 0x00B/0x00C, overflow 0x00D.
// - First 8-bit timer match A, B, overflow go to 0x00E, 0x00F, 0x010.
// - SPI done 0x011; serial receive, buffer empty, transmit 0x012-0x014.
// - Conversion done 0x015, data memory ready 0x016, comparator 0x017.
// - Two-wire 0x018, program store ready 0x019, start edge 0x01A last.
// - Slot spans one word in smaller variants, two in the largest.
// - Smallest variant has no boot section; addresses never relocate.
// - Larger variants: reset follows boot fuse, base follows select bit.
// - Select bit set: vector is boot start plus table address.
// - Fuse programmed (0) resets to boot address, else to 0x000.
`timescale 1ns/1ps
`default_nettype none
`include "ivm_defs.svh"
module ivm_vector_map #(
  parameter ivm_pkg::ivm_variant_e VARIANT = ivm_pkg::IVM_VAR_MID,
  parameter logic [`IVM_ADDR_W-1:0] BOOT_START = `IVM_BOOT_START
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic sysResetReq,
  input wire logic [`IVM_NUM_SRC-1:0] irqPending,
  input wire logic [`IVM_NUM_SRC-1:0] irqEnable,
  input wire logic globalIrqEnable,
  input wire logic boot_reset_select_fuse,
  input wire logic vector_base_select,
  input wire logic vecAck,
  output logic vecValid,
  output logic resetJump,
  output logic [`IVM_ADDR_W-1:0] vecAddr,
  output logic [4:0] vecSlot
);

  // Slot of the lowest-numbered enabled request; 0 means none
  function automatic logic [4:0] pickSlot(input logic [`IVM_NUM_SRC-1:0] req);
    logic [4:0] s;
    s = 5'h00;
    for (int i = `IVM_NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        s = 5'(i + 1);
      end
    end
    return s;
  endfunction : pickSlot

  // Address of a slot from base and slot size
  function automatic logic [`IVM_ADDR_W-1:0] slotAddr(input logic [4:0] slot,
                                                       input logic relocate);
    logic [`IVM_ADDR_W-1:0] base;
    logic [`IVM_ADDR_W-1:0] offs;
    base = `IVM_RESET_ADDR;
    offs = {{(`IVM_ADDR_W-5){1'b0}}, slot};
    if (VARIANT == ivm_pkg::IVM_VAR_LARGE) begin
      offs = offs << 1;
    end
    if (relocate && VARIANT != ivm_pkg::IVM_VAR_SMALL) begin
      base = BOOT_START;
    end
    return base + offs;
  endfunction : slotAddr

  ivm_pkg::ivm_state_e state_r, state_nxt;
  logic vecValid_r, vecValid_nxt;
  logic resetJump_r, resetJump_nxt;
  logic [`IVM_ADDR_W-1:0] vecAddr_r, vecAddr_nxt;
  logic [4:0] vecSlot_r, vecSlot_nxt;
  logic [4:0] winSlot;
  logic [`IVM_ADDR_W-1:0] resetTarget;

  assign winSlot = globalIrqEnable ? pickSlot(irqPending & irqEnable) : 5'h00;

  // Reset target: fuse only matters where a boot section exists
  always_comb begin
    resetTarget = `IVM_RESET_ADDR;
    if (VARIANT != ivm_pkg::IVM_VAR_SMALL && !boot_reset_select_fuse) begin
      resetTarget = BOOT_START;
    end
  end

  // Offer held until taken, or until a reset request drops it
  always_comb begin
    state_nxt = state_r;
    vecValid_nxt = vecValid_r;
    resetJump_nxt = 1'b0;
    vecAddr_nxt = vecAddr_r;
    vecSlot_nxt = vecSlot_r;
    case (state_r)
      ivm_pkg::IVM_ST_RESET: begin
        // Reset request wins over any pending interrupt
        state_nxt = ivm_pkg::IVM_ST_IDLE;
        vecValid_nxt = 1'b0;
      end
      ivm_pkg::IVM_ST_IDLE: begin
        if (winSlot != 5'h00) begin
          state_nxt = ivm_pkg::IVM_ST_VECT;
          vecValid_nxt = 1'b1;
          vecSlot_nxt = winSlot;
          vecAddr_nxt = slotAddr(winSlot, vector_base_select);
        end
      end
      ivm_pkg::IVM_ST_VECT: begin
        if (vecAck) begin
          state_nxt = ivm_pkg::IVM_ST_IDLE;
          vecValid_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ivm_pkg::IVM_ST_IDLE;
        vecValid_nxt = 1'b0;
      end
    endcase
    if (sysResetReq) begin
      state_nxt = ivm_pkg::IVM_ST_RESET;
      vecValid_nxt = 1'b0;
      resetJump_nxt = 1'b1;
      vecSlot_nxt = 5'h00;
      vecAddr_nxt = resetTarget;
    end
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ivm_pkg::IVM_ST_RESET;
      vecValid_r <= 1'b0;
      resetJump_r <= 1'b1;
      vecAddr_r <= `IVM_RESET_ADDR;
      vecSlot_r <= 5'h00;
    end else if (clkEn) begin
      state_r <= state_nxt;
      vecValid_r <= vecValid_nxt;
      resetJump_r <= resetJump_nxt;
      vecAddr_r <= vecAddr_nxt;
      vecSlot_r <= vecSlot_nxt;
    end
  end

  assign vecValid = vecValid_r;
  assign resetJump = resetJump_r;
  assign vecAddr = vecAddr_r;
  assign vecSlot = vecSlot_r;

  // Reset request always yields a reset jump next enabled edge
  chk_reset_wins: assert property (@(posedge clk) disable iff (rst)
    (clkEn && sysResetReq) |=> (resetJump && !vecValid && vecSlot == 5'h00))
    else $error("reset request did not win");

  chk_reset_target: assert property (@(posedge clk) disable iff (rst)
    (clkEn && sysResetReq) |=> (vecAddr == (($past(boot_reset_select_fuse)
      || VARIANT == ivm_pkg::IVM_VAR_SMALL) ? `IVM_RESET_ADDR : BOOT_START)))
    else $error("wrong reset target");

  chk_vec_hold: assert property (@(posedge clk) disable iff (rst)
    (vecValid && !vecAck && !sysResetReq) |=> (vecValid && $stable(vecAddr)))
    else $error("offered vector dropped");

  chk_small_fixed: assert property (@(posedge clk) disable iff (rst)
    (VARIANT == ivm_pkg::IVM_VAR_SMALL && vecValid) |->
      (vecAddr == {{(`IVM_ADDR_W-5){1'b0}}, vecSlot}))
    else $error("small variant vector moved");

  chk_large_space: assert property (@(posedge clk) disable iff (rst)
    (VARIANT == ivm_pkg::IVM_VAR_LARGE && vecValid && !vector_base_select
     && $past(!vector_base_select)) |-> (vecAddr[0] == 1'b0))
    else $error("large variant slot not two words");

  chk_lowest_wins: assert property (@(posedge clk) disable iff (rst)
    (clkEn && state_r == ivm_pkg::IVM_ST_IDLE && !sysResetReq && globalIrqEnable
     && (irqPending[0] & irqEnable[0])) |=> (vecValid && vecSlot == `IVM_SLOT_EXT0))
    else $error("lowest source not chosen");

  chk_last_slot: assert property (@(posedge clk) disable iff (rst)
    (clkEn && state_r == ivm_pkg::IVM_ST_IDLE && !sysResetReq && globalIrqEnable
     && (irqPending & irqEnable) == 26'h200_0000) |=> (vecSlot == `IVM_SLOT_LAST))
    else $error("start edge slot wrong");

  chk_no_mask: assert property (@(posedge clk) disable iff (rst)
    (clkEn && state_r == ivm_pkg::IVM_ST_IDLE && !globalIrqEnable) |=> !vecValid)
    else $error("vector offered with interrupts off");

endmodule : ivm_vector_map
`default_nettype wire

// ---- ivm_core_model.sv ----
/*
  Core-side model: takes each offered vector and acknowledges it once.
  Assumes the vector map holds its offer until it has seen the acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic vecValid,
  input wire logic [3:0] ackDelay,
  output logic vecAck
);
  logic [3:0] waitCnt_r;
  // Ack after ackDelay cycles; a one-cycle pulse so one offer gets one ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt_r <= 4'h0;
      vecAck <= 1'b0;
    end else begin
      vecAck <= vecValid && !vecAck && (waitCnt_r >= ackDelay);
      waitCnt_r <= (vecValid && !vecAck) ? waitCnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : ivm_core_model
`default_nettype wire

// ---- interrupt_vector_map_tb_top.sv ----
/*
  Testbench of the vector map, middle variant, with a core model acking.
  Assumes ivm_defs.svh on the include path and the default BOOT_START.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ivm_defs.svh"
module interrupt_vector_map_tb_top;
  logic clk, rst, sysResetReq, globalIrqEnable, fuseBit, baseSel, vecAck, vecValid, resetJump;
  logic [25:0] irqPending, irqEnable;
  logic [13:0] vecAddr;
  logic [4:0] vecSlot;
  logic [3:0] ackDelay;
  logic clkEn;
  int bad_count = 0;
  int compares = 0;
  ivm_vector_map ivm_vector_map_i (.clk(clk), .rst(rst), .clkEn(clkEn),
    .sysResetReq(sysResetReq), .irqPending(irqPending), .irqEnable(irqEnable),
    .globalIrqEnable(globalIrqEnable), .boot_reset_select_fuse(fuseBit),
    .vector_base_select(baseSel), .vecAck(vecAck), .vecValid(vecValid),
    .resetJump(resetJump), .vecAddr(vecAddr), .vecSlot(vecSlot));
  ivm_core_model ivm_core_model_i (.clk(clk), .rst(rst), .vecValid(vecValid),
    .ackDelay(ackDelay), .vecAck(vecAck));
  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic conclude();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Bounded wait for the offer flag to reach a level
  task automatic waitValid(input logic lvl);
    int n;
    n = 0;
    while (vecValid !== lvl && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({13'h0000, vecValid}, {13'h0000, lvl});
    if (vecValid !== lvl) conclude();
  endtask : waitValid
  task automatic offer(input logic [25:0] pend, input logic [13:0] addr, input logic [4:0] slot);
    @(posedge clk);
    irqPending <= pend;
    waitValid(1'b1);
    check(vecAddr, addr);
    check({9'h000, vecSlot}, {9'h000, slot});
    @(posedge clk);
    irqPending <= 26'h000_0000;
    waitValid(1'b0);
  endtask : offer
  // Held in reset: reset jump shown, nothing offered
  task automatic scnReset();
    repeat (11) @(posedge clk);
    #1;
    check({resetJump, vecValid, vecAddr[11:0]}, 14'h2000);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({13'h0000, resetJump}, 14'h0000);
  endtask : scnReset
  // Clock enable low freezes the map; the held request is offered once it rises
  task automatic scnFreeze();
    @(posedge clk);
    clkEn <= 1'b0;
    irqPending <= 26'h000_0002;
    repeat (4) @(posedge clk);
    #1;
    check({13'h0000, vecValid}, 14'h0000);
    @(posedge clk);
    clkEn <= 1'b1;
    waitValid(1'b1);
    check(vecAddr, 14'h0002);
    @(posedge clk);
    irqPending <= 26'h000_0000;
    waitValid(1'b0);
  endtask : scnFreeze
  // Every source alone, mixed prompt and slow acks
  task automatic scnAllSources();
    for (int i = 0; i < 26; i++) begin
      ackDelay = 4'(i % 4);
      offer(26'h000_0001 << i, 14'(i + 1), 5'(i + 1));
    end
  endtask : scnAllSources
  task automatic scnPriority();
    offer(26'h300_0010, 14'h0005, 5'h05);
    offer(26'h200_0001, 14'h0001, 5'h01);
  endtask : scnPriority
  // Masked by source enable, then by the global enable
  task automatic scnMasked();
    @(posedge clk);
    irqEnable <= 26'h3ff_fffe;
    irqPending <= 26'h000_0001;
    repeat (5) @(posedge clk);
    #1;
    check({13'h0000, vecValid}, 14'h0000);
    irqEnable <= 26'h3ff_ffff;
    globalIrqEnable <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({13'h0000, vecValid}, 14'h0000);
    @(posedge clk);
    irqPending <= 26'h000_0000;
    globalIrqEnable <= 1'b1;
  endtask : scnMasked
  task automatic scnRelocate();
    @(posedge clk);
    baseSel <= 1'b1;
    offer(26'h000_0004, `IVM_BOOT_START + 14'h0003, 5'h03);
    baseSel <= 1'b0;
  endtask : scnRelocate
  // System reset with a request pending; reset entry follows the fuse
  task automatic scnSysReset(input logic fuse, input logic [13:0] addr);
    @(posedge clk);
    fuseBit <= fuse;
    sysResetReq <= 1'b1;
    irqPending <= 26'h000_0001;
    @(posedge clk);
    sysResetReq <= 1'b0;
    irqPending <= 26'h000_0000;
    #1;
    check({resetJump, vecValid, 12'h000}, 14'h2000);
    check(vecAddr, addr);
    @(posedge clk);
    #1;
    check({resetJump, vecValid, 12'h000}, 14'h0000);
  endtask : scnSysReset
  initial begin
    rst = 1'b1;
    sysResetReq = 1'b0;
    globalIrqEnable = 1'b1;
    fuseBit = 1'b1;
    baseSel = 1'b0;
    irqPending = 26'h000_0000;
    irqEnable = 26'h3ff_ffff;
    ackDelay = 4'h0;
    clkEn = 1'b1;
    scnReset();
    scnFreeze();
    scnAllSources();
    scnPriority();
    scnMasked();
    scnRelocate();
    scnSysReset(1'b1, `IVM_RESET_ADDR);
    scnSysReset(1'b0, `IVM_BOOT_START);
    conclude();
  end
endmodule : interrupt_vector_map_tb_top
`default_nettype wire
